// ### rtl/scp_pkg.sv
// constants, types and carriers for the stop and clear policy controller
package scp_pkg;

  // ------------------------------------------------------------------
  // policy setting values
  // ------------------------------------------------------------------
  localparam logic [4:0]  POLICY_RESET   = 5'h0e;
  localparam logic [4:0]  POLICY_LO_MAX  = 5'h03;
  localparam logic [4:0]  POLICY_HI_MIN  = 5'h0e;
  localparam logic [4:0]  POLICY_HI_MAX  = 5'h11;

  // ------------------------------------------------------------------
  // other settings
  // ------------------------------------------------------------------
  localparam logic [1:0]  WP_STOP_ONLY   = 2'h0;
  localparam logic [1:0]  WP_LOCKED      = 2'h1;
  localparam logic [1:0]  WP_ANY_TIME    = 2'h2;
  localparam logic [1:0]  WP_RESET       = 2'h0;
  localparam logic [13:0] SETTING_AUTO   = 14'h270f;
  localparam logic [13:0] CMD_SET_UNIT   = 14'h0001;
  localparam logic [13:0] CMD_SET_USB    = 14'h0002;
  localparam logic [1:0]  SRC_PANEL      = 2'h0;
  localparam logic [1:0]  SRC_UNIT       = 2'h1;
  localparam logic [1:0]  SRC_USB        = 2'h2;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0]  ADDR_POLICY    = 8'h00;
  localparam logic [7:0]  ADDR_WP        = 8'h04;
  localparam logic [7:0]  ADDR_STOP_METH = 8'h08;
  localparam logic [7:0]  ADDR_CMD_SRC   = 8'h0c;
  localparam logic [7:0]  ADDR_CTRL      = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;
  localparam int          CTRL_PCLR_BIT  = 0;
  localparam int          CTRL_ACLR_BIT  = 1;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          TICK_TIME_NS   = 1000000;
  localparam int          TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int          ABSENT_TIME_MS = 1000;
  localparam int          ABSENT_TICKS   = ABSENT_TIME_MS * 1000000 / TICK_TIME_NS;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    HOLD_IDLE = 3'b001,
    HOLD_EXT  = 3'b010,
    HOLD_UNIT = 3'b100
  } scp_hold_e;

  typedef struct packed {
    logic external_clear_terminal;
    logic unit_present;
    logic panel_stop_key;
    logic unit_stop_key;
    logic unit_clear_key;
    logic outside_mode_key;
    logic forward_run_command;
    logic reverse_run_command;
    logic usb_connected;
  } scp_pins_s;

  typedef struct packed {
    logic trip_active;
    logic motor_running;
    logic motor_stopped;
    logic unit_mode;
    logic unit_jog;
    logic rs485_on_unit_port;
    logic comm_clear_req;
  } scp_drive_s;

  typedef struct packed {
    logic       output_off;
    logic       clear_accepted;
    logic       thermal_clear;
    logic       brake_duty_clear;
    logic       key_stop_decel;
    logic       jog_stop_decel;
    logic       alarm_stop;
    logic       keypad_stop_hold;
    logic       detached_unit_alarm;
    logic       run_permit;
    logic       coast_select;
    logic [1:0] command_source;
  } scp_ctrl_s;

endpackage

// ### rtl/scp_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // pins in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } scp_sync_s;

  scp_sync_s s_r;
  scp_sync_s s_nxt;

  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.stage1 = din;
    s_nxt.stage2 = s_r.stage1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign dout = s_r.stage2;

endmodule // scp_sync
`default_nettype wire

// ### rtl/scp_absence_timer.sv
// operator unit absence timer on a fixed internal tick
`timescale 1ns/1ps
`default_nettype none
module scp_absence_timer #(
  parameter int TICK_CYCLES  = scp_pkg::TICK_CYCLES,
  parameter int ABSENT_TICKS = scp_pkg::ABSENT_TICKS
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic unit_present,
  input  wire logic enable,
  // result
  output logic      expired
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int TW = $clog2(ABSENT_TICKS + 2);

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [TW-1:0] ticks;
    logic          expired;
  } scp_tmr_s;

  scp_tmr_s s_r;
  scp_tmr_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (unit_present || !enable)
    begin
      s_nxt = '0; // RULE23
    end
    else if (s_r.presc == PW'(TICK_CYCLES - 1))
    begin
      s_nxt.presc = '0;
      if (s_r.ticks == TW'(ABSENT_TICKS))
        s_nxt.expired = 1'b1; // RULE8
      else
        s_nxt.ticks = s_r.ticks + TW'(1); // RULE23
    end
    else
    begin
      s_nxt.presc = s_r.presc + PW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign expired = s_r.expired;

endmodule // scp_absence_timer
`default_nettype wire

// ### rtl/scp_policy_ctrl.sv
// stop and clear policy controller with its AHB-Lite register slave
//
// Behaviour
// RULE1 - policy legal 0-3/14-17, resets to 14
// RULE2 - policy writable during run despite protect
// RULE3 - parameter clears leave policy untouched
// RULE4 - odd policies: clear only while tripped
// RULE5 - even policies: clear accepted any time
// RULE6 - accepted clear coasts, zeroes thermal, brake
// RULE7 - unit clear key works only when tripped
// RULE8 - detect policies: alarm after 1s absence
// RULE9 - other policies: keep running, no alarm
// RULE10 - absence before power-up never alarms
// RULE11 - unit jog removal decelerates to stop
// RULE12 - RS-485 on unit port disables detection
// RULE13 - policy 14-17 external stop: decel, hold
// RULE14 - policy 0-3: no hold, unit mode only
// RULE15 - no restart in hold; origin cancels
// RULE16 - power cycle or clear terminal cancels
// RULE17 - panel hold cancels entering unit mode
// RULE18 - unit hold cancels on its mode key
// RULE19 - key stop decelerates whatever stop method
// RULE20 - unit mode: non-source stop key holds
// RULE21 - auto source: USB, unit, then panel
// RULE22 - unit-source hold cancels leaving unit mode
// RULE23 - absence counter restarts on presence
// RULE24 - illegal policy writes are ignored
`timescale 1ns/1ps
`default_nettype none
module scp_policy_ctrl #(
  parameter int TICK_CYCLES  = scp_pkg::TICK_CYCLES,
  parameter int ABSENT_TICKS = scp_pkg::ABSENT_TICKS
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // pins, asynchronous
  input  wire scp_pkg::scp_pins_s pins,
  // drive state, same clock
  input  wire scp_pkg::scp_drive_s drive,
  // control outputs
  output scp_pkg::scp_ctrl_s      ctrl
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [4:0]        policy;
    logic [1:0]        wp;
    logic [13:0]       stop_method;
    logic [13:0]       cmd_src;
    scp_pkg::scp_hold_e hold;
    logic              hold_from_unit;
    logic              hold_ack;
    logic              alarm;
    logic              seen_present;
    logic              prev_unit_mode;
    scp_pkg::scp_pins_s prev;
    logic              wr_pend;
    logic [7:0]        addr;
    logic [31:0]       rdata;
    scp_pkg::scp_ctrl_s out;
  } scp_state_s;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic pol_legal(input logic [4:0] p);
    pol_legal = (p <= scp_pkg::POLICY_LO_MAX) ||
                ((p >= scp_pkg::POLICY_HI_MIN) && (p <= scp_pkg::POLICY_HI_MAX));
  endfunction

  function automatic logic pol_trip_only(input logic [4:0] p);
    pol_trip_only = p[0];
  endfunction

  // 2 and 3 have bit 1 set, 16 and 17 have it clear
  function automatic logic pol_detect(input logic [4:0] p);
    pol_detect = p[1] ^ (p >= scp_pkg::POLICY_HI_MIN);
  endfunction

  function automatic logic pol_all_modes(input logic [4:0] p);
    pol_all_modes = (p >= scp_pkg::POLICY_HI_MIN);
  endfunction

  function automatic logic [1:0] src_sel(input logic [13:0] set, input logic usb,
                                         input logic present);
    if (set == scp_pkg::SETTING_AUTO)
    begin
      if (usb)
        src_sel = scp_pkg::SRC_USB; // RULE21
      else if (present)
        src_sel = scp_pkg::SRC_UNIT; // RULE21
      else
        src_sel = scp_pkg::SRC_PANEL; // RULE21
    end
    else if (set == scp_pkg::CMD_SET_UNIT)
      src_sel = scp_pkg::SRC_UNIT;
    else if (set == scp_pkg::CMD_SET_USB)
      src_sel = scp_pkg::SRC_USB;
    else
      src_sel = scp_pkg::SRC_PANEL;
  endfunction

  scp_state_s         s_r;
  scp_state_s         s_nxt;
  scp_pkg::scp_pins_s pin_q;
  logic               absent_expired;
  logic               detect_en;
  logic               term_rise;
  logic               ext_ok;
  logic               key_ok;
  logic               accept;
  logic               stop_press;
  logic               press_unit;
  logic               runs_off;
  logic               set_ok;
  logic [1:0]         src;
  logic               nonsrc;

  // ------------------------------------------------------------------
  // pin synchroniser and absence timer
  // ------------------------------------------------------------------
  scp_sync #(
    .W ($bits(scp_pkg::scp_pins_s))
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pins),
    .dout    (pin_q)
  );

  scp_absence_timer #(
    .TICK_CYCLES  (TICK_CYCLES),
    .ABSENT_TICKS (ABSENT_TICKS)
  ) u_timer (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .unit_present (pin_q.unit_present),
    .enable       (detect_en),
    .expired      (absent_expired)
  );

  // detection only after a presence was seen, never through the rs-485 port
  assign detect_en = pol_detect(s_r.policy) && s_r.seen_present &&
                     !drive.rs485_on_unit_port; // RULE8 RULE9 RULE10 RULE12

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.prev = pin_q;
    s_nxt.prev_unit_mode = drive.unit_mode;
    s_nxt.out.output_off       = 1'b0;
    s_nxt.out.clear_accepted   = 1'b0;
    s_nxt.out.thermal_clear    = 1'b0;
    s_nxt.out.brake_duty_clear = 1'b0;
    s_nxt.out.key_stop_decel   = 1'b0;
    s_nxt.out.jog_stop_decel   = 1'b0;

    // clear acceptance
    term_rise = pin_q.external_clear_terminal && !s_r.prev.external_clear_terminal;
    ext_ok    = (term_rise || drive.comm_clear_req) &&
                (!pol_trip_only(s_r.policy) || drive.trip_active); // RULE4 RULE5
    key_ok    = pin_q.unit_clear_key && !s_r.prev.unit_clear_key &&
                drive.trip_active; // RULE7
    accept    = ext_ok || key_ok;
    s_nxt.out.clear_accepted   = accept;
    s_nxt.out.thermal_clear    = accept; // RULE6
    s_nxt.out.brake_duty_clear = accept; // RULE6
    s_nxt.out.output_off       = accept && drive.motor_running; // RULE6

    // detached unit
    if (pin_q.unit_present)
      s_nxt.seen_present = 1'b1; // RULE10
    s_nxt.alarm = (s_r.alarm && !accept) || (absent_expired && detect_en); // RULE8
    if (absent_expired && detect_en && !s_r.alarm)
      s_nxt.out.output_off = 1'b1; // RULE8
    s_nxt.out.jog_stop_decel = s_r.prev.unit_present && !pin_q.unit_present &&
                               !pol_detect(s_r.policy) && drive.unit_jog; // RULE11

    // stop keys and hold
    src        = src_sel(s_r.cmd_src, pin_q.usb_connected, pin_q.unit_present);
    press_unit = pin_q.unit_stop_key && !s_r.prev.unit_stop_key;
    stop_press = press_unit || (pin_q.panel_stop_key && !s_r.prev.panel_stop_key);
    nonsrc     = press_unit ? (src != scp_pkg::SRC_UNIT) : (src != scp_pkg::SRC_PANEL);
    runs_off   = !pin_q.forward_run_command && !pin_q.reverse_run_command;

    if (term_rise && ext_ok)
      s_nxt.hold = scp_pkg::HOLD_IDLE; // RULE16
    case (s_r.hold)
      scp_pkg::HOLD_EXT:
      begin
        if (!s_r.hold_from_unit && drive.unit_mode && !s_r.prev_unit_mode &&
            runs_off && drive.motor_stopped)
          s_nxt.hold = scp_pkg::HOLD_IDLE; // RULE17 RULE15
        if (s_r.hold_from_unit && pin_q.outside_mode_key && !s_r.prev.outside_mode_key &&
            runs_off && drive.motor_stopped)
          s_nxt.hold = scp_pkg::HOLD_IDLE; // RULE18 RULE15
      end
      scp_pkg::HOLD_UNIT:
      begin
        if (pin_q.unit_clear_key && !s_r.prev.unit_clear_key && drive.motor_stopped)
          s_nxt.hold_ack = 1'b1; // RULE22
        if (!drive.unit_mode && s_r.prev_unit_mode && drive.motor_stopped &&
            (s_r.hold_ack || src != scp_pkg::SRC_UNIT))
          s_nxt.hold = scp_pkg::HOLD_IDLE; // RULE22 RULE15
      end
      default:
      begin
        s_nxt.hold_ack = 1'b0;
      end
    endcase

    if (stop_press && drive.unit_mode)
    begin
      s_nxt.out.key_stop_decel = 1'b1; // RULE14 RULE19
      if (pol_all_modes(s_r.policy) && nonsrc)
      begin
        s_nxt.hold           = scp_pkg::HOLD_UNIT; // RULE20
        s_nxt.hold_from_unit = press_unit;
        s_nxt.hold_ack       = 1'b0;
      end
    end
    else if (stop_press && pol_all_modes(s_r.policy))
    begin
      s_nxt.out.key_stop_decel = 1'b1; // RULE13 RULE19
      s_nxt.hold               = scp_pkg::HOLD_EXT; // RULE13
      s_nxt.hold_from_unit     = press_unit;
      s_nxt.hold_ack           = 1'b0;
    end

    // register writes in the data phase
    set_ok = (s_r.wp == scp_pkg::WP_ANY_TIME) ||
             ((s_r.wp == scp_pkg::WP_STOP_ONLY) && !drive.motor_running);
    if (s_r.wr_pend)
    begin
      if (s_r.addr == scp_pkg::ADDR_POLICY)
      begin
        if (pol_legal(hwdata[4:0]) && (hwdata[31:5] == '0))
          s_nxt.policy = hwdata[4:0]; // RULE2 RULE24
      end
      else if (s_r.addr == scp_pkg::ADDR_WP)
      begin
        if (hwdata[31:0] <= 32'(scp_pkg::WP_ANY_TIME))
          s_nxt.wp = hwdata[1:0];
      end
      else if (s_r.addr == scp_pkg::ADDR_STOP_METH)
      begin
        if (set_ok)
          s_nxt.stop_method = hwdata[13:0];
      end
      else if (s_r.addr == scp_pkg::ADDR_CMD_SRC)
      begin
        if (set_ok)
          s_nxt.cmd_src = hwdata[13:0];
      end
      else if (s_r.addr == scp_pkg::ADDR_CTRL)
      begin
        if ((hwdata[scp_pkg::CTRL_PCLR_BIT] || hwdata[scp_pkg::CTRL_ACLR_BIT]) &&
            (s_r.wp != scp_pkg::WP_LOCKED))
        begin
          s_nxt.stop_method = scp_pkg::SETTING_AUTO; // RULE3
          s_nxt.cmd_src     = scp_pkg::SETTING_AUTO; // RULE3
        end
      end
    end

    // outputs follow the next state, except the command source, which follows the current setting and pins
    s_nxt.out.alarm_stop          = s_nxt.alarm;
    s_nxt.out.detached_unit_alarm = s_nxt.alarm;
    s_nxt.out.keypad_stop_hold    = (s_nxt.hold != scp_pkg::HOLD_IDLE);
    s_nxt.out.run_permit          = (s_nxt.hold == scp_pkg::HOLD_IDLE) &&
                                    !s_nxt.alarm; // RULE15
    s_nxt.out.coast_select        = (s_nxt.stop_method != scp_pkg::SETTING_AUTO);
    s_nxt.out.command_source      = src;

    // address phase and read data
    s_nxt.wr_pend = hsel && hready && htrans[1] && hwrite;
    s_nxt.rdata   = '0;
    if (hsel && hready && htrans[1])
      s_nxt.addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      if (haddr[7:0] == scp_pkg::ADDR_POLICY)
        s_nxt.rdata = {27'h0000000, s_nxt.policy};
      else if (haddr[7:0] == scp_pkg::ADDR_WP)
        s_nxt.rdata = {30'h00000000, s_nxt.wp};
      else if (haddr[7:0] == scp_pkg::ADDR_STOP_METH)
        s_nxt.rdata = {18'h00000, s_nxt.stop_method};
      else if (haddr[7:0] == scp_pkg::ADDR_CMD_SRC)
        s_nxt.rdata = {18'h00000, s_nxt.cmd_src};
      else if (haddr[7:0] == scp_pkg::ADDR_STATUS)
        s_nxt.rdata = {25'h0000000, pin_q.unit_present, s_nxt.seen_present, src,
                       s_nxt.hold_from_unit, s_nxt.alarm, s_nxt.out.keypad_stop_hold};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r                <= '0;
      s_r.policy         <= scp_pkg::POLICY_RESET; // RULE1
      s_r.wp             <= scp_pkg::WP_RESET;
      s_r.stop_method    <= scp_pkg::SETTING_AUTO;
      s_r.cmd_src        <= scp_pkg::SETTING_AUTO;
      s_r.hold           <= scp_pkg::HOLD_IDLE; // RULE16
      s_r.out.run_permit <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.rdata;
  assign ctrl      = s_r.out;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_policy_legal: assert property (pol_legal(s_r.policy)) // RULE1
    else $error("policy holds an illegal value");
  a_bad_write_kept: assert property (s_r.wr_pend && s_r.addr == scp_pkg::ADDR_POLICY &&
      !pol_legal(hwdata[4:0]) |=> $stable(s_r.policy)) // RULE24
    else $error("illegal policy write changed the setting");
  a_trip_gate: assert property (pol_trip_only(s_r.policy) && !drive.trip_active &&
      !key_ok |=> !ctrl.clear_accepted) // RULE4
    else $error("clear accepted without a trip");
  a_clear_any_time: assert property (!pol_trip_only(s_r.policy) && term_rise
      |=> ctrl.clear_accepted) // RULE5
    else $error("clear refused under always-accept policy");
  a_clear_coasts: assert property (accept && drive.motor_running
      |=> ctrl.output_off && ctrl.thermal_clear && ctrl.brake_duty_clear) // RULE6
    else $error("accepted clear did not coast and zero estimates");
  a_key_trip_only: assert property ($rose(pin_q.unit_clear_key) && !drive.trip_active &&
      !ext_ok |=> !ctrl.clear_accepted) // RULE7
    else $error("unit clear key acted without a trip");
  a_alarm_cause: assert property ($rose(s_r.alarm) |-> // RULE8
      $past(detect_en && absent_expired))
    else $error("alarm raised without qualified absence");
  a_no_hold_low: assert property ($rose(ctrl.keypad_stop_hold)
      |-> $past(pol_all_modes(s_r.policy))) // RULE14
    else $error("stop hold entered under policy 0 to 3");
  a_hold_blocks: assert property (ctrl.keypad_stop_hold |-> !ctrl.run_permit) // RULE15
    else $error("restart permitted during stop hold");
  a_term_cancel: assert property ((term_rise && ext_ok && !stop_press) ##1 !stop_press // RULE16
      |-> !ctrl.keypad_stop_hold ##1 !ctrl.keypad_stop_hold)
    else $error("clear terminal did not cancel stop hold");

  c_ext_hold: cover property (s_r.hold == scp_pkg::HOLD_EXT ##[1:50]
      s_r.hold == scp_pkg::HOLD_IDLE);
  c_unit_hold: cover property (s_r.hold == scp_pkg::HOLD_UNIT);
  c_alarm: cover property ($rose(ctrl.detached_unit_alarm));
  c_clear: cover property (ctrl.clear_accepted && ctrl.output_off);

endmodule // scp_policy_ctrl
`default_nettype wire

// ### tb/scp_partner.sv
// operator side model: keys, operator unit presence and run commands
`timescale 1ns/1ps
`default_nettype none
module scp_partner (
  // clock
  input  wire logic             hclk,
  // pins towards the drive
  output var scp_pkg::scp_pins_s pins
);
  initial pins = '0;

  // a key is held for four cycles, then left up for four more
  task key(input int b);
    @(posedge hclk);
    pins[b] <= 1'b1;
    repeat (4) @(posedge hclk);
    pins[b] <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task lvl(input int b, input logic v);
    @(posedge hclk);
    pins[b] <= v;
  endtask

  // operator drops both run commands before a restart
  task runs_off;
    @(posedge hclk);
    pins.forward_run_command <= 1'b0;
    pins.reverse_run_command <= 1'b0;
  endtask
endmodule // scp_partner
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the stop and clear policy controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int K_CLR = 8, K_PRES = 7, K_PSTOP = 6, K_USTOP = 5;
  localparam int K_UCLR = 4, K_FWD = 2, K_USB = 0;
  logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd, seed;
  scp_pkg::scp_pins_s  pins;
  scp_pkg::scp_drive_s drv;
  scp_pkg::scp_ctrl_s  ctrl;
  int                 n_mismatch, checked, n_acc, n_off, n_dec, n_jog, a0, o0, d0, m_pol;
  int                 pl[8] = '{0, 1, 2, 3, 14, 15, 16, 17};
  assign hready = hreadyout;

  scp_policy_ctrl #(.TICK_CYCLES(4), .ABSENT_TICKS(5)) i_scp_policy_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
    .drive(drv), .ctrl(ctrl));
  scp_partner i_scp_partner (.hclk(hclk), .pins(pins));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    if ((ctrl.clear_accepted & ctrl.thermal_clear & ctrl.brake_duty_clear) === 1'b1) n_acc++;
    if (ctrl.output_off === 1'b1) n_off++;
    if (ctrl.key_stop_decel === 1'b1) n_dec++;
    if (ctrl.jog_stop_decel === 1'b1) n_jog++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
      begin
        n_mismatch++;
        $display("BAD %0t got %h exp %h", $time, g, e);
      end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task print_verdict;
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    print_verdict;
  end

  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    drv = '0;
    seed = 32'h98e9;
    m_pol = 14;
    cyc(6);
    hresetn <= 1'b1;
    ahb(1'b0, scp_pkg::ADDR_POLICY, 32'h0);
    chk(rd, 32'he);
    chk({hresp, hreadyout}, 32'h1);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // random policy values written while running with protect at stop-only
    drv.motor_running <= 1'b1;
    repeat (24)
    begin
      seed = xs(seed);
      ahb(1'b1, scp_pkg::ADDR_POLICY, {27'h0, seed[4:0]});
      if (seed[4:0] <= 3 || (seed[4:0] >= 14 && seed[4:0] <= 17)) m_pol = seed[4:0];
      ahb(1'b0, scp_pkg::ADDR_POLICY, 32'h0);
      chk(rd, m_pol);
    end
    ahb(1'b1, scp_pkg::ADDR_CTRL, 32'h3);
    ahb(1'b0, scp_pkg::ADDR_POLICY, 32'h0);
    chk(rd, m_pol);
    // clear terminal gating across every policy, tripped and not
    foreach (pl[i])
      for (int t = 0; t < 2; t++)
      begin
        ahb(1'b1, scp_pkg::ADDR_POLICY, pl[i]);
        drv.trip_active <= t[0];
        a0 = n_acc;
        o0 = n_off;
        i_scp_partner.key(K_CLR);
        drv.comm_clear_req <= 1'b1;
        cyc(1);
        drv.comm_clear_req <= 1'b0;
        cyc(4);
        chk(n_acc - a0, 2 * ((pl[i] % 2 == 0) || t));
        chk(n_off - o0, 2 * ((pl[i] % 2 == 0) || t));
      end
    ahb(1'b1, scp_pkg::ADDR_POLICY, 32'he);
    for (int t = 0; t < 2; t++)
    begin
      drv.trip_active <= t[0];
      a0 = n_acc;
      i_scp_partner.key(K_UCLR);
      cyc(4);
      chk(n_acc - a0, t);
    end
    // stop key in external mode with coasting selected
    drv.trip_active <= 1'b0;
    drv.motor_running <= 1'b0;
    ahb(1'b1, scp_pkg::ADDR_STOP_METH, 32'h0);
    drv.motor_running <= 1'b1;
    i_scp_partner.lvl(K_FWD, 1'b1);
    chk(ctrl.coast_select, 32'h1);
    for (int p = 0; p < 15; p += 14)
    begin
      ahb(1'b1, scp_pkg::ADDR_POLICY, p);
      d0 = n_dec;
      i_scp_partner.key(K_PSTOP);
      cyc(4);
      chk(n_dec - d0, p == 14);
      chk(ctrl.keypad_stop_hold, p == 14);
      chk(ctrl.run_permit, p != 14);
      chk(ctrl.alarm_stop | ctrl.detached_unit_alarm, 32'h0);
    end
    i_scp_partner.runs_off();
    drv.motor_running <= 1'b0;
    drv.motor_stopped <= 1'b1;
    cyc(2);
    drv.unit_mode <= 1'b1;
    cyc(5);
    chk(ctrl.keypad_stop_hold, 32'h0);
    drv.unit_mode <= 1'b0;
    i_scp_partner.key(K_PSTOP);
    chk(ctrl.keypad_stop_hold, 32'h1);
    i_scp_partner.key(K_CLR);
    cyc(4);
    chk(ctrl.keypad_stop_hold, 32'h0);
    // unit stop key in unit mode while the panel is the source
    ahb(1'b1, scp_pkg::ADDR_CMD_SRC, 32'h0);
    drv.unit_mode <= 1'b1;
    i_scp_partner.key(K_USTOP);
    cyc(4);
    chk(ctrl.keypad_stop_hold, 32'h1);
    ahb(1'b0, scp_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h5);
    i_scp_partner.key(K_CLR);
    drv.unit_mode <= 1'b0;
    // panel stop key in unit mode while the unit is the source
    ahb(1'b1, scp_pkg::ADDR_CMD_SRC, 32'h1);
    drv.unit_mode <= 1'b1;
    i_scp_partner.key(K_PSTOP);
    drv.unit_mode <= 1'b0;
    cyc(4);
    chk(ctrl.keypad_stop_hold, 32'h1);
    drv.unit_mode <= 1'b1;
    i_scp_partner.key(K_UCLR);
    drv.unit_mode <= 1'b0;
    cyc(4);
    chk(ctrl.keypad_stop_hold, 32'h0);
    ahb(1'b1, scp_pkg::ADDR_CMD_SRC, 32'h270f);
    i_scp_partner.lvl(K_PRES, 1'b1);
    i_scp_partner.lvl(K_USB, 1'b1);
    cyc(5);
    chk(ctrl.command_source, 32'h2);
    i_scp_partner.lvl(K_USB, 1'b0);
    cyc(5);
    chk(ctrl.command_source, 32'h1);
    drv.unit_jog <= 1'b1;
    d0 = n_jog;
    i_scp_partner.lvl(K_PRES, 1'b0);
    cyc(40);
    chk(n_jog - d0, 32'h1);
    drv.unit_jog <= 1'b0;
    chk(ctrl.command_source, 32'h0);
    chk(ctrl.detached_unit_alarm, 32'h0);
    // second reset with the unit already absent
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    ahb(1'b1, scp_pkg::ADDR_POLICY, 32'h10);
    cyc(60);
    chk(ctrl.detached_unit_alarm, 32'h0);
    i_scp_partner.lvl(K_PRES, 1'b1);
    cyc(8);
    i_scp_partner.lvl(K_PRES, 1'b0);
    cyc(14);
    i_scp_partner.lvl(K_PRES, 1'b1);
    cyc(4);
    i_scp_partner.lvl(K_PRES, 1'b0);
    cyc(14);
    chk(ctrl.detached_unit_alarm, 32'h0);
    cyc(21);
    chk(ctrl.detached_unit_alarm, 32'h1);
    chk(ctrl.alarm_stop, 32'h1);
    drv.rs485_on_unit_port <= 1'b1;
    i_scp_partner.key(K_CLR);
    cyc(40);
    chk(ctrl.detached_unit_alarm, 32'h0);
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
